// ==== hdl/otp_delay_timer.v ====
`timescale 1ns/1ps
// one-shot down counter; o_done pulses one cycle after expiry
module otp_delay_timer #(
    parameter W = 16
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_srst,
    // control
    input wire i_start,
    input wire [W-1:0] i_count,
    // status
    output reg o_done
);
    reg [W-1:0] cnt_q;
    reg run_q;

    // count down from the loaded value
    always @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            cnt_q <= {W{1'b0}};
            run_q <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_start)
            begin
                cnt_q <= i_count;
                run_q <= 1'b1;
            end
            else if (run_q)
            begin
                if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
                begin
                    run_q <= 1'b0;
                    o_done <= 1'b1;
                end
                else
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // otp_delay_timer

// ==== hdl/otp_prog_defines.vh ====
`ifndef OTP_PROG_DEFINES_VH
`define OTP_PROG_DEFINES_VH
// clock rate
`define CLK_PERIOD_PS 25000
// program pulse window in ns; the nominal figure is driven
`define PULSE_MIN_NS 95000
`define PULSE_NOM_NS 100000
`define PULSE_MAX_NS 105000
// nominal pulse in clocks, sized to the timer so no bits are dropped
`define PULSE_CYC 16'h0FA0
// setup and hold figures in ns
`define SETUP_NS 2000
// cycle counts are the ns figures over the clock period, rounded up
`define SETUP_CYC 16'h0050
`define OE_DATA_NS 150
`define OE_DATA_CYC 16'h0006
`define FLOAT_NS 130
`define FLOAT_CYC 16'h0006
// retry limit per address
`define RETRY_MAX 4'hA
// supply selection codes
`define SUP_READ 2'h0
`define SUP_PROG 2'h1
// identification line bit position
`define ID_LINE_BIT 9
`endif

// ==== hdl/otp_programmer.v ====
`timescale 1ns/1ps
`include "otp_prog_defines.vh"
module otp_programmer #(
    parameter AW = 19,
    parameter [AW-1:0] LAST_ADDR = {AW{1'b1}},
    parameter [15:0] PULSE_CYC = `PULSE_CYC,
    parameter [7:0] EXP_MAKER = 8'h5A, // arbitrary value
    parameter [7:0] EXP_DEVICE = 8'hA5 // arbitrary value
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_srst,
    // user commands
    input wire i_start_prog,
    input wire i_start_id,
    // image data for the current address
    input wire [7:0] i_img_data,
    // memory pins
    input wire [7:0] i_mem_dq,
    output reg [AW-1:0] o_mem_addr,
    output reg [7:0] o_mem_dq,
    output reg o_mem_dq_oe,
    output reg o_chip_en_n,
    output reg o_out_en_n,
    output reg o_id_mode_high_voltage_line,
    output reg [1:0] o_supply_sel,
    // status
    output reg o_busy,
    output reg o_done,
    output reg o_pass,
    output reg o_fail,
    output reg [7:0] o_maker_code,
    output reg [7:0] o_device_code,
    output reg o_id_match
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_SETUP = 4'h1;
    localparam [3:0] S_PULSE = 4'h2;
    localparam [3:0] S_HOLD = 4'h3;
    localparam [3:0] S_VREAD = 4'h4;
    localparam [3:0] S_VFLOAT = 4'h5;
    localparam [3:0] S_RDSET = 4'h6;
    localparam [3:0] S_RREAD = 4'h7;
    localparam [3:0] S_RFLOAT = 4'h8;
    localparam [3:0] S_IDSET = 4'h9;
    localparam [3:0] S_IDREAD = 4'hA;
    localparam [3:0] S_END = 4'hB;
    localparam [1:0] PH_BLIND = 2'h0;
    localparam [1:0] PH_VERIFY = 2'h1;
    localparam [1:0] PH_READ = 2'h2;

    reg [3:0] st_q;
    reg [1:0] ph_q;
    reg [3:0] retry_q;
    reg bad_q;
    reg tmr_start;
    reg [15:0] tmr_count;
    wire tmr_done;

    // last address reached test, used on several branches
    function last_addr;
        input [AW-1:0] a;
        begin
            last_addr = (a == LAST_ADDR);
        end
    endfunction

    otp_delay_timer #(.W(16)) u_timer (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_start(tmr_start),
        .i_count(tmr_count),
        .o_done(tmr_done)
    );

    // sequencer; timer is kicked on every state entry except S_END and S_IDLE
    always @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            st_q <= S_IDLE;
            ph_q <= PH_BLIND;
            retry_q <= 4'h0;
            bad_q <= 1'b0;
            tmr_start <= 1'b0;
            tmr_count <= 16'h0000;
            o_mem_addr <= {AW{1'b0}};
            o_mem_dq <= 8'h00;
            o_mem_dq_oe <= 1'b0;
            o_chip_en_n <= 1'b1;
            o_out_en_n <= 1'b1;
            o_id_mode_high_voltage_line <= 1'b0;
            o_supply_sel <= `SUP_READ;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_pass <= 1'b0;
            o_fail <= 1'b0;
            o_maker_code <= 8'h00;
            o_device_code <= 8'h00;
            o_id_match <= 1'b0;
        end
        else
        begin
            tmr_start <= 1'b0;
            o_done <= 1'b0;
            case (st_q)
                S_IDLE:
                begin
                    if (i_start_prog)
                    begin
                        // address zero and supplies up on one edge; address is already parked at zero
                        o_mem_addr <= {AW{1'b0}};
                        o_supply_sel <= `SUP_PROG;
                        ph_q <= PH_BLIND;
                        retry_q <= 4'h0;
                        bad_q <= 1'b0;
                        o_busy <= 1'b1;
                        o_pass <= 1'b0;
                        o_fail <= 1'b0;
                        tmr_count <= `SETUP_CYC;
                        tmr_start <= 1'b1;
                        st_q <= S_SETUP;
                    end
                    else if (i_start_id)
                    begin
                        // high line up, rest low, bit zero picks the byte
                        o_mem_addr <= {AW{1'b0}};
                        o_id_mode_high_voltage_line <= 1'b1;
                        o_busy <= 1'b1;
                        tmr_count <= `SETUP_CYC;
                        tmr_start <= 1'b1;
                        st_q <= S_IDSET;
                    end
                end
                S_SETUP:
                begin
                    // data and address settle before the pulse
                    o_mem_dq <= i_img_data;
                    o_mem_dq_oe <= 1'b1;
                    if (tmr_done)
                    begin
                        o_chip_en_n <= 1'b0;
                        tmr_count <= PULSE_CYC;
                        tmr_start <= 1'b1;
                        st_q <= S_PULSE;
                    end
                end
                S_PULSE:
                begin
                    if (tmr_done)
                    begin
                        o_chip_en_n <= 1'b1; // fixed width of PULSE_CYC plus two clocks
                        tmr_count <= `SETUP_CYC;
                        tmr_start <= 1'b1;
                        st_q <= S_HOLD;
                    end
                end
                S_HOLD:
                begin
                    if (tmr_done)
                    begin
                        o_mem_dq_oe <= 1'b0;
                        if (ph_q == PH_BLIND)
                        begin
                            // no verify in the first pass
                            if (last_addr(o_mem_addr))
                            begin
                                ph_q <= PH_VERIFY;
                                o_mem_addr <= {AW{1'b0}};
                                retry_q <= 4'h0;
                            end
                            else
                                o_mem_addr <= o_mem_addr + {{(AW-1){1'b0}}, 1'b1};
                            tmr_count <= `SETUP_CYC;
                            tmr_start <= 1'b1;
                            st_q <= (last_addr(o_mem_addr)) ? S_RDSET : S_SETUP;
                        end
                        else
                        begin
                            tmr_count <= `SETUP_CYC;
                            tmr_start <= 1'b1;
                            st_q <= S_RDSET;
                        end
                    end
                end
                S_RDSET:
                begin
                    // oe setup elapsed, drop oe and wait data valid
                    if (tmr_done)
                    begin
                        o_out_en_n <= 1'b0;
                        // plain read at read supply needs chip enable as well
                        if (ph_q == PH_READ)
                            o_chip_en_n <= 1'b0;
                        tmr_count <= `OE_DATA_CYC;
                        tmr_start <= 1'b1;
                        st_q <= S_VREAD;
                    end
                end
                S_VREAD:
                begin
                    // sample only after the data delay
                    if (tmr_done)
                    begin
                        o_out_en_n <= 1'b1;
                        o_chip_en_n <= 1'b1;
                        tmr_count <= `FLOAT_CYC;
                        tmr_start <= 1'b1;
                        st_q <= (ph_q == PH_READ) ? S_RFLOAT : S_VFLOAT;
                        if (ph_q == PH_READ && i_mem_dq != i_img_data)
                            bad_q <= 1'b1;
                        else if (ph_q == PH_VERIFY)
                            bad_q <= (i_mem_dq != i_img_data);
                    end
                end
                S_VFLOAT:
                begin
                    if (tmr_done)
                    begin
                        if (bad_q)
                        begin
                            if (retry_q == `RETRY_MAX)
                            begin
                                o_fail <= 1'b1;
                                st_q <= S_END;
                            end
                            else
                            begin
                                retry_q <= retry_q + 4'h1;
                                tmr_count <= `SETUP_CYC;
                                tmr_start <= 1'b1;
                                st_q <= S_SETUP;
                            end
                        end
                        else if (last_addr(o_mem_addr))
                        begin
                            // supplies down, full readback
                            o_supply_sel <= `SUP_READ;
                            ph_q <= PH_READ;
                            o_mem_addr <= {AW{1'b0}};
                            tmr_count <= `SETUP_CYC;
                            tmr_start <= 1'b1;
                            st_q <= S_RDSET;
                        end
                        else
                        begin
                            // next address, fresh retry count
                            o_mem_addr <= o_mem_addr + {{(AW-1){1'b0}}, 1'b1};
                            retry_q <= 4'h0;
                            tmr_count <= `SETUP_CYC;
                            tmr_start <= 1'b1;
                            st_q <= S_RDSET;
                        end
                    end
                end
                S_RFLOAT:
                begin
                    if (tmr_done)
                    begin
                        if (last_addr(o_mem_addr))
                        begin
                            o_pass <= ~bad_q;
                            o_fail <= bad_q;
                            st_q <= S_END;
                        end
                        else
                        begin
                            o_mem_addr <= o_mem_addr + {{(AW-1){1'b0}}, 1'b1};
                            tmr_count <= `SETUP_CYC;
                            tmr_start <= 1'b1;
                            st_q <= S_RDSET;
                        end
                    end
                end
                S_IDSET:
                begin
                    // both strobes low; data waits the full delay
                    if (tmr_done)
                    begin
                        o_chip_en_n <= 1'b0;
                        o_out_en_n <= 1'b0;
                        tmr_count <= `OE_DATA_CYC;
                        tmr_start <= 1'b1;
                        st_q <= S_IDREAD;
                    end
                end
                S_IDREAD:
                begin
                    if (tmr_done)
                    begin
                        if (o_mem_addr[0] == 1'b0)
                        begin
                            o_maker_code <= i_mem_dq;
                            o_mem_addr[0] <= 1'b1; // select device byte
                            tmr_count <= `OE_DATA_CYC;
                            tmr_start <= 1'b1;
                        end
                        else
                        begin
                            o_device_code <= i_mem_dq;
                            o_id_match <= (o_maker_code == EXP_MAKER) &&
                                (i_mem_dq == EXP_DEVICE);
                            o_chip_en_n <= 1'b1;
                            o_out_en_n <= 1'b1;
                            o_id_mode_high_voltage_line <= 1'b0;
                            o_mem_addr <= {AW{1'b0}};
                            st_q <= S_END;
                        end
                    end
                end
                S_END:
                begin
                    // park on the first location so a later run raises supplies on it
                    o_mem_addr <= {AW{1'b0}};
                    o_supply_sel <= `SUP_READ;
                    o_mem_dq_oe <= 1'b0;
                    o_chip_en_n <= 1'b1;
                    o_out_en_n <= 1'b1;
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    st_q <= S_IDLE;
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end
endmodule // otp_programmer

// ==== sim/otp_mem_model.sv ====
`timescale 1ns/1ps
`include "otp_prog_defines.vh"
// blank part; a byte sticks only after i_need pulses
module otp_mem_model #(
    parameter AW = 19,
    parameter [7:0] MAKER = 8'h3D, // arbitrary value
    parameter [7:0] DEVICE = 8'hC4 // arbitrary value
) (
    // pins
    input wire [AW-1:0] i_addr,
    input wire [7:0] i_dq,
    input wire i_dq_oe,
    input wire i_chip_en_n,
    input wire i_out_en_n,
    input wire i_id_line,
    input wire [1:0] i_supply_sel,
    // scenario control
    input wire [4:0] i_need,
    input wire i_fresh,
    output reg [7:0] o_dq
);
    reg [7:0] mem [0:3];
    reg [4:0] pulses [0:3];
    reg [7:0] last = 8'h00;
    integer k;
    wire [1:0] a = i_addr[1:0];
    wire drive = !i_out_en_n && (i_supply_sel == `SUP_PROG || !i_chip_en_n);
    wire [7:0] val = (i_id_line && i_addr[AW-1:1] == 0) ? (i_addr[0] ? DEVICE : MAKER) : mem[a];
    wire [7:0] val_d;
    wire drive_d;
    // one delay from address or gate, so a late gate adds nothing
    assign #60 val_d = val;
    assign #60 drive_d = drive;
    // swap in a new blank part
    always @(posedge i_fresh)
    begin
        for (k = 0; k < 4; k = k + 1)
        begin
            mem[k] = 8'hFF;
            pulses[k] = 5'h00;
        end
    end
    // a pulse counts when the strobe rises at programming supply
    always @(posedge i_chip_en_n)
    begin
        if (i_out_en_n && i_dq_oe && i_supply_sel == `SUP_PROG)
        begin
            pulses[a] = pulses[a] + 5'h01;
            if (pulses[a] >= i_need)
                mem[a] = mem[a] & i_dq;
        end
    end
    // a released bus shows a changed value, never the held one
    always @*
    begin
        if (drive_d)
        begin
            o_dq = val_d;
            last = val_d;
        end
        else
            o_dq = ~last;
    end
endmodule // otp_mem_model

// ==== sim/otp_prog_chk.sv ====
`timescale 1ns/1ps
`include "otp_prog_defines.vh"
// watches the memory pins and run status of the programmer
module otp_prog_chk #(
    parameter AW = 19,
    parameter [15:0] PULSE_CYC = 16'h0014
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_srst,
    // memory pins
    input wire [AW-1:0] o_mem_addr,
    input wire [7:0] o_mem_dq,
    input wire o_mem_dq_oe,
    input wire o_chip_en_n,
    input wire o_out_en_n,
    input wire o_id_mode_high_voltage_line,
    input wire [1:0] o_supply_sel,
    // status
    input wire o_busy,
    input wire o_done,
    input wire o_pass,
    input wire o_fail,
    input wire o_id_match
);
    reg [15:0] low_q;
    reg [4:0] pulses_q;
    reg [AW-1:0] addr_q;
    reg chip_q;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // pulse length and pulses per address; a new address restarts the count
    always @(posedge i_core_clk)
    begin
        addr_q <= o_mem_addr;
        chip_q <= o_chip_en_n;
        if (i_srst)
            low_q <= 16'h0000;
        else
            low_q <= (!o_chip_en_n && o_out_en_n) ? low_q + 16'h0001 : 16'h0000;
        if (i_srst || !o_busy || o_mem_addr != addr_q)
            pulses_q <= 5'h00;
        else if (!o_chip_en_n && chip_q && o_out_en_n)
            pulses_q <= pulses_q + 5'h01;
    end
    property p_pulse_min;
        // the timer adds two clocks to the nominal count
        o_chip_en_n && low_q != 16'h0000 |-> low_q == PULSE_CYC + 16'h0002;
    endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("program pulse short");
    property p_pulse_max;
        low_q <= PULSE_CYC + 16'h0002;
    endproperty
    a_pulse_max: assert property (p_pulse_max) else $error("program pulse long");
    property p_pulse_stable;
        !o_chip_en_n && o_out_en_n && !$past(o_chip_en_n) |-> $stable(o_mem_addr) && $stable(o_mem_dq);
    endproperty
    a_pulse_stable: assert property (p_pulse_stable) else $error("pins moved in pulse");
    property p_first_addr;
        $rose(o_supply_sel == `SUP_PROG) |-> o_mem_addr == 0 && $past(o_mem_addr) == 0;
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("supply up off first address");
    property p_pulse_supply;
        !o_chip_en_n && o_out_en_n |-> o_mem_dq_oe && o_supply_sel == `SUP_PROG;
    endproperty
    a_pulse_supply: assert property (p_pulse_supply) else $error("pulse without supply or data");
    property p_retry_limit;
        pulses_q <= 5'h0A;
    endproperty
    a_retry_limit: assert property (p_retry_limit) else $error("too many pulses at one address");
    property p_verify_wait;
        $fell(o_out_en_n) |-> !o_out_en_n [*6];
    endproperty
    a_verify_wait: assert property (p_verify_wait) else $error("output gate too short");
    property p_no_fight;
        !o_out_en_n |-> !o_mem_dq_oe;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("host drives data while reading");
    property p_read_no_pulse;
        o_supply_sel == `SUP_READ && !o_chip_en_n |-> !o_out_en_n;
    endproperty
    a_read_no_pulse: assert property (p_read_no_pulse) else $error("pulse at read supply");
    property p_id_lines;
        o_id_mode_high_voltage_line |-> o_mem_addr[AW-1:1] == 0;
    endproperty
    a_id_lines: assert property (p_id_lines) else $error("id mode address lines not low");
    c_pass: cover property (o_done && o_pass);
    c_fail: cover property (o_done && o_fail);
    c_id: cover property ($rose(o_id_match));
endmodule // otp_prog_chk

bind otp_programmer otp_prog_chk #(.AW(AW), .PULSE_CYC(PULSE_CYC)) chk_inst (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .o_mem_addr(o_mem_addr), .o_mem_dq(o_mem_dq),
    .o_mem_dq_oe(o_mem_dq_oe), .o_chip_en_n(o_chip_en_n), .o_out_en_n(o_out_en_n),
    .o_id_mode_high_voltage_line(o_id_mode_high_voltage_line), .o_supply_sel(o_supply_sel),
    .o_busy(o_busy), .o_done(o_done), .o_pass(o_pass), .o_fail(o_fail), .o_id_match(o_id_match)
);

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`include "otp_prog_defines.vh"
module tb;
    localparam AW = 19;
    reg i_core_clk = 1'b0;
    reg i_srst = 1'b1;
    reg start_prog = 1'b0;
    reg start_id = 1'b0;
    reg [4:0] need = 5'h01;
    reg fresh = 1'b0;
    wire [AW-1:0] addr;
    wire [7:0] host_dq, dev_dq, maker, device;
    wire dq_oe, ce_n, oe_n, id_line, busy, done, pass, fail, id_match;
    wire [1:0] sup;
    integer err_count = 0;
    integer n_compared = 0;
    integer i;
    function [7:0] img_of(input [1:0] a);
        img_of = 8'h96 ^ {a, a, a, a};
    endfunction
    otp_programmer #(.AW(AW), .LAST_ADDR(19'h00003), .PULSE_CYC(16'h0014),
        .EXP_MAKER(8'h3D), .EXP_DEVICE(8'hC4)) otp_programmer_inst (
        .i_core_clk(i_core_clk), .i_srst(i_srst), .i_start_prog(start_prog),
        .i_start_id(start_id), .i_img_data(img_of(addr[1:0])), .i_mem_dq(dev_dq),
        .o_mem_addr(addr), .o_mem_dq(host_dq), .o_mem_dq_oe(dq_oe), .o_chip_en_n(ce_n),
        .o_out_en_n(oe_n), .o_id_mode_high_voltage_line(id_line), .o_supply_sel(sup),
        .o_busy(busy), .o_done(done), .o_pass(pass), .o_fail(fail),
        .o_maker_code(maker), .o_device_code(device), .o_id_match(id_match));
    otp_mem_model #(.AW(AW)) otp_mem_model_inst (
        .i_addr(addr), .i_dq(host_dq), .i_dq_oe(dq_oe), .i_chip_en_n(ce_n),
        .i_out_en_n(oe_n), .i_id_line(id_line), .i_supply_sel(sup), .i_need(need),
        .i_fresh(fresh), .o_dq(dev_dq));
    // clock
    initial forever #12.5 i_core_clk = ~i_core_clk;
    task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask
    task wrap_up;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // start a command pulse and wait a bounded time for done
    task run(input [4:0] n, input id);
        integer c;
        @(posedge i_core_clk);
        #1 need = n;
        fresh = !id;
        start_prog = !id;
        start_id = id;
        @(posedge i_core_clk);
        #1 fresh = 1'b0;
        start_prog = 1'b0;
        start_id = 1'b0;
        c = 0;
        while (done !== 1'b1 && c < 40000)
        begin
            @(posedge i_core_clk);
            #1 c = c + 1;
            if (c == 10)
                start_id = 1'b1;
            if (c == 11)
                start_id = 1'b0;
        end
        check(done, 1, "run end");
        check(busy, 0, "busy at end");
    endtask
    // every byte sticks at the first pulse
    task t_clean;
        run(5'h01, 1'b0);
        check(pass, 1, "pass");
        check(fail, 0, "fail");
        check(sup, `SUP_READ, "supply");
        check(maker, 0, "id start while busy");
        for (i = 0; i < 4; i = i + 1)
        begin
            check(otp_mem_model_inst.pulses[i], 1, "blind pulses");
            check(otp_mem_model_inst.mem[i], img_of(i), "byte");
        end
    endtask
    // a byte spoilt after verify must fail the readback
    task t_rdback;
        fork
            run(5'h01, 1'b0);
            begin
                wait (sup == `SUP_PROG);
                wait (sup == `SUP_READ);
                otp_mem_model_inst.mem[2] = 8'h00;
            end
        join
        check(fail, 1, "readback fail");
        check(pass, 0, "readback pass");
    endtask
    // each byte needs the full ten retries
    task t_retry;
        run(5'h0B, 1'b0);
        check(pass, 1, "pass");
        for (i = 0; i < 4; i = i + 1)
            check(otp_mem_model_inst.pulses[i], 11, "retry pulses");
    endtask
    // first byte never sticks
    task t_fail;
        run(5'h0C, 1'b0);
        check(fail, 1, "fail");
        check(pass, 0, "pass");
        check(otp_mem_model_inst.pulses[0], 11, "pulses at failed byte");
        check(otp_mem_model_inst.pulses[1], 1, "no verify past failure");
    endtask
    // both identification bytes
    task t_id;
        run(5'h01, 1'b1);
        check(maker, 8'h3D, "maker");
        check(device, 8'hC4, "device");
        check(id_match, 1, "id match");
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge i_core_clk);
        #1 i_srst = 1'b0;
        t_clean;
        t_rdback;
        t_retry;
        t_fail;
        t_id;
        wrap_up;
    end
    // watchdog well past the expected run
    initial
    begin
        #(25 * 90000);
        err_count = err_count + 1;
        wrap_up;
    end
endmodule // tb
